// *** kef_keyscan_map.svh ***
`ifndef KEF_KEYSCAN_MAP_SVH
`define KEF_KEYSCAN_MAP_SVH
// ****************************************************************
// register map
// ****************************************************************
`define KEF_REG_QUEUE    8'h00
`define KEF_REG_CFG      8'h01
`define KEF_CFG_SLEEP    7
`define KEF_CFG_INTMODE  5
`define KEF_CFG_RELEN    3
`define KEF_CFG_AWAKE    1
`define KEF_CFG_TMODIS   0
// reserved bits 6, 4, 2 never store and read as zero
`define KEF_CFG_WMASK    8'h2B
`define KEF_CFG_RST      8'h08
// ****************************************************************
// queue read codes and entry layout {repeat, release, key[5:0]}
// ****************************************************************
`define KEF_CODE_EMPTY   8'h3F
`define KEF_CODE_OVF     8'h7F
`define KEF_KEY_RPT      6'h3E
`define KEF_KEY_HIGH     6'h3E
`define KEF_ENT_RPT      7
`define KEF_ENT_REL      6
// ****************************************************************
// timing
// ****************************************************************
`define KEF_CLK_MHZ      100
`define KEF_AUTOSLEEP_MS 8
`define KEF_I2C_TMO_US   30
`define KEF_DEV_ADDR     7'h38
`endif

// *** kef_pkg.sv ***
package kef_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_AACK, ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
    } kef_i2c_state_type;
endpackage

// *** kef_keyscan_fifo.sv ***
`include "kef_keyscan_map.svh"
// Notes on behaviour
// - low six bits carry key number
// - bit 7 set while more entries remain
// - bit 6 set for release, clear press
// - keys 62/63 always bit 7 set
// - empty and overflow have fixed codes
// - autorepeat code, bit 6 means more follow
// - pwm enable keeps keys active, ignores sleep writes
// - sleep changed by host, autosleep, autowake
// - mode 0 interrupt clears when queue empty
module kef_keyscan_fifo #(
    parameter int        DEPTH         = 16,
    parameter logic [6:0] DEV_ADDR     = `KEF_DEV_ADDR,
    parameter int        AUTOSLEEP_CYC = `KEF_AUTOSLEEP_MS * 1000 * `KEF_CLK_MHZ,
    parameter int        TMO_CYC       = `KEF_I2C_TMO_US * `KEF_CLK_MHZ
) (
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    input  wire logic       evt_valid,
    output logic            evt_ready,
    input  wire logic [5:0] evt_key,
    input  wire logic       evt_release,
    input  wire logic       evt_repeat,
    input  wire logic       pwm_cc_en,
    input  wire logic       autosleep_en,
    output logic            key_active,
    output logic            key_int_n
);
    localparam int AW = $clog2(DEPTH);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [2:0] scl_m_r, sda_m_r;
    logic       scl_q_r, sda_q_r, scl_nxt, sda_nxt;
    logic       scl_rise, scl_fall, i2c_start, i2c_stop;

    always_ff @(posedge core_clk) begin
        scl_m_r <= {scl_m_r[1:0], scl_i};
        sda_m_r <= {sda_m_r[1:0], sda_i};
        scl_q_r <= srst ? 1'b1 : scl_nxt;
        sda_q_r <= srst ? 1'b1 : sda_nxt;
    end

    // a level only counts once the second and third stages agree
    assign scl_nxt   = (scl_m_r[1] == scl_m_r[2]) ? scl_m_r[2] : scl_q_r;
    assign sda_nxt   = (sda_m_r[1] == sda_m_r[2]) ? sda_m_r[2] : sda_q_r;
    assign scl_rise  = scl_nxt & ~scl_q_r;
    assign scl_fall  = ~scl_nxt & scl_q_r;
    assign i2c_start = scl_q_r & scl_nxt & sda_q_r & ~sda_nxt;
    assign i2c_stop  = scl_q_r & scl_nxt & ~sda_q_r & sda_nxt;

    // ****************************************************************
    // i2c slave protocol
    // ****************************************************************
    kef_pkg::kef_i2c_state_type state_r;
    logic [7:0]  shift_r, tx_r, ptr_r, cfg_r, rd_byte;
    logic [2:0]  bit_cnt_r;
    logic        got8_r, rw_r, nack_r, wfirst_r;
    logic [31:0] tmo_cnt_r;
    logic        tmo_hit, wr_byte, byte_load, q_read;

    assign tmo_hit   = !cfg_r[`KEF_CFG_TMODIS] && tmo_cnt_r >= 32'(TMO_CYC);
    assign wr_byte   = scl_fall && state_r == kef_pkg::ST_WDATA && got8_r;
    assign byte_load = scl_fall && ((state_r == kef_pkg::ST_AACK && rw_r) ||
                                    (state_r == kef_pkg::ST_RACK && !nack_r));
    assign q_read    = byte_load && ptr_r == `KEF_REG_QUEUE;

    always_ff @(posedge core_clk) begin
        if (srst || i2c_start) begin
            state_r   <= i2c_start ? kef_pkg::ST_ADDR : kef_pkg::ST_IDLE;
            bit_cnt_r <= 3'h0;
            got8_r    <= 1'b0;
            if (srst) begin
                shift_r  <= 8'h00;
                rw_r     <= 1'b0;
                nack_r   <= 1'b0;
                wfirst_r <= 1'b0;
            end
        end else if (i2c_stop || tmo_hit) begin
            state_r <= kef_pkg::ST_IDLE;
        end else begin
            unique case (state_r)
                kef_pkg::ST_IDLE: ;
                kef_pkg::ST_ADDR, kef_pkg::ST_WDATA: begin
                    if (scl_rise) begin
                        shift_r   <= {shift_r[6:0], sda_nxt};
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                        got8_r    <= bit_cnt_r == 3'h7;
                    end else if (scl_fall && got8_r) begin
                        got8_r <= 1'b0;
                        if (state_r == kef_pkg::ST_WDATA) begin
                            state_r  <= kef_pkg::ST_WACK;
                            wfirst_r <= 1'b0;
                        end else if (shift_r[7:1] == DEV_ADDR) begin
                            state_r  <= kef_pkg::ST_AACK;
                            rw_r     <= shift_r[0];
                            wfirst_r <= ~shift_r[0];
                        end else begin
                            state_r <= kef_pkg::ST_IDLE;
                        end
                    end
                end
                kef_pkg::ST_AACK:
                    if (scl_fall) state_r <= rw_r ? kef_pkg::ST_RDATA : kef_pkg::ST_WDATA;
                kef_pkg::ST_WACK:
                    if (scl_fall) state_r <= kef_pkg::ST_WDATA;
                kef_pkg::ST_RDATA: begin
                    if (scl_rise) begin
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                        got8_r    <= bit_cnt_r == 3'h7;
                    end else if (scl_fall && got8_r) begin
                        got8_r  <= 1'b0;
                        state_r <= kef_pkg::ST_RACK;
                    end
                end
                kef_pkg::ST_RACK: begin
                    if (scl_rise)
                        nack_r <= sda_nxt;
                    else if (scl_fall)
                        state_r <= nack_r ? kef_pkg::ST_IDLE : kef_pkg::ST_RDATA;
                end
                // the eighth code of the three-bit state is unused
                default: state_r <= kef_pkg::ST_IDLE;
            endcase
        end
    end

    // a stuck master holding scl low would otherwise hang the slave
    always_ff @(posedge core_clk) begin
        if (srst || state_r == kef_pkg::ST_IDLE || scl_q_r)
            tmo_cnt_r <= 32'h0;
        else if (!tmo_hit)
            tmo_cnt_r <= tmo_cnt_r + 32'h1;
    end

    // queue pointer stays put so the host can drain it in one burst
    always_ff @(posedge core_clk) begin
        if (srst)
            ptr_r <= 8'h00;
        else if (wr_byte)
            ptr_r <= wfirst_r ? shift_r : ptr_r + 8'h01;
        else if (byte_load && ptr_r != `KEF_REG_QUEUE)
            ptr_r <= ptr_r + 8'h01;
    end

    always_ff @(posedge core_clk) begin
        if (srst)
            tx_r <= 8'hFF;
        else if (byte_load)
            tx_r <= rd_byte;
        else if (scl_fall && state_r == kef_pkg::ST_RDATA && !got8_r)
            tx_r <= {tx_r[6:0], 1'b1};
    end

    assign sda_o  = 1'b0;
    assign sda_oe = state_r == kef_pkg::ST_AACK || state_r == kef_pkg::ST_WACK ||
                    (state_r == kef_pkg::ST_RDATA && !tx_r[7]);

    // ****************************************************************
    // configuration and sleep
    // ****************************************************************
    localparam logic [7:0] CFG_RST = `KEF_CFG_RST;
    logic        wr_cfg, sleep_r, wake_evt, evt_fire, keep_evt;
    logic [31:0] idle_cnt_r;

    assign wr_cfg   = wr_byte && !wfirst_r && ptr_r == `KEF_REG_CFG;
    assign evt_fire = evt_valid && evt_ready;
    assign wake_evt = evt_fire && !key_active && cfg_r[`KEF_CFG_AWAKE] && !evt_release;
    assign key_active = sleep_r || pwm_cc_en;

    always_ff @(posedge core_clk) begin
        if (srst)
            cfg_r <= `KEF_CFG_RST & `KEF_CFG_WMASK;
        else if (wr_cfg)
            cfg_r <= shift_r & `KEF_CFG_WMASK;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            sleep_r    <= CFG_RST[`KEF_CFG_SLEEP];
            idle_cnt_r <= 32'h0;
        end else begin
            idle_cnt_r <= (evt_fire || !sleep_r) ? 32'h0 : idle_cnt_r + 32'h1;
            if (wake_evt)
                sleep_r <= 1'b1;
            else if (wr_cfg && !pwm_cc_en)
                sleep_r <= shift_r[`KEF_CFG_SLEEP];
            else if (autosleep_en && !pwm_cc_en && idle_cnt_r >= 32'(AUTOSLEEP_CYC))
                sleep_r <= 1'b0;
        end
    end

    // ****************************************************************
    // two-entry input buffer and event queue
    // ****************************************************************
    logic [7:0]    buf_mem [2];
    logic          b_wr_r, b_rd_r;
    logic [1:0]    b_cnt_r;
    logic [7:0]    q_mem [DEPTH];
    logic [AW-1:0] q_wr_r, q_rd_r;
    logic [AW:0]   q_cnt_r;
    logic          b_push, b_pop, q_pop, ovf_r, int_pend_r;
    logic [7:0]    head;

    assign evt_ready = b_cnt_r != 2'h2;
    // sleeping keys other than an autowake press, and masked releases, are taken and thrown away
    assign keep_evt  = (key_active || wake_evt) && !(evt_release && !cfg_r[`KEF_CFG_RELEN]);
    assign b_push    = evt_fire && keep_evt;
    assign b_pop     = b_cnt_r != 2'h0 && q_cnt_r != (AW+1)'(DEPTH);
    assign head      = q_mem[q_rd_r];
    assign q_pop     = q_read && !ovf_r && q_cnt_r != '0;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            b_wr_r  <= 1'b0;
            b_rd_r  <= 1'b0;
            b_cnt_r <= 2'h0;
        end else begin
            if (b_push) begin
                buf_mem[b_wr_r] <= {evt_repeat, evt_release, evt_key};
                b_wr_r          <= ~b_wr_r;
            end
            if (b_pop)
                b_rd_r <= ~b_rd_r;
            b_cnt_r <= b_cnt_r + {1'b0, b_push} - {1'b0, b_pop};
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            q_wr_r  <= '0;
            q_rd_r  <= '0;
            q_cnt_r <= '0;
        end else begin
            if (b_pop) begin
                q_mem[q_wr_r] <= buf_mem[b_rd_r];
                q_wr_r        <= AW'((q_wr_r + 1'b1) % DEPTH);
            end
            if (q_pop)
                q_rd_r <= AW'((q_rd_r + 1'b1) % DEPTH);
            q_cnt_r <= q_cnt_r + {{AW{1'b0}}, b_pop} - {{AW{1'b0}}, q_pop};
        end
    end

    // overflow: source offered a key while everything was full; set beats clear
    always_ff @(posedge core_clk) begin
        if (srst)
            ovf_r <= 1'b0;
        else if (evt_valid && !evt_ready)
            ovf_r <= 1'b1;
        else if (q_read)
            ovf_r <= 1'b0;
    end

    function automatic logic [7:0] queue_code(input logic ovf, input logic [AW:0] cnt,
                                              input logic [7:0] ent);
        logic more;
        more = cnt > (AW+1)'(1);
        if (ovf)
            queue_code = `KEF_CODE_OVF;
        else if (cnt == '0)
            queue_code = `KEF_CODE_EMPTY;
        else if (ent[`KEF_ENT_RPT])
            queue_code = {1'b0, more, `KEF_KEY_RPT};
        else if (ent[5:0] >= `KEF_KEY_HIGH)
            queue_code = {1'b1, ent[`KEF_ENT_REL], ent[5:0]};
        else
            queue_code = {more, ent[`KEF_ENT_REL], ent[5:0]};
    endfunction

    always_comb begin
        if (ptr_r == `KEF_REG_QUEUE)
            rd_byte = queue_code(ovf_r, q_cnt_r, head);
        else if (ptr_r == `KEF_REG_CFG)
            rd_byte = {key_active, cfg_r[6:0]};
        else
            rd_byte = 8'h00;
    end

    // ****************************************************************
    // interrupt
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (srst)
            int_pend_r <= 1'b0;
        else if (b_pop)
            int_pend_r <= 1'b1;
        else if (q_read)
            int_pend_r <= 1'b0;
    end

    assign key_int_n = cfg_r[`KEF_CFG_INTMODE] ? ~int_pend_r : ~(q_cnt_r != '0 || ovf_r);

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    logic qnorm;
    assign qnorm = q_read && !ovf_r && q_cnt_r != '0 && !head[`KEF_ENT_RPT];

    chk_key_number: assert property (qnorm |=> tx_r[5:0] == $past(head[5:0]))
        else $error("key number wrong in queue byte");
    chk_more_flag: assert property (qnorm && head[5:0] < `KEF_KEY_HIGH |=> tx_r[7] == $past(q_cnt_r > 1))
        else $error("more flag wrong");
    chk_release_flag: assert property (qnorm |=> tx_r[6] == $past(head[`KEF_ENT_REL]))
        else $error("release flag wrong");
    chk_high_keys: assert property (qnorm && head[5:0] >= `KEF_KEY_HIGH |=> tx_r[7])
        else $error("key 62/63 without bit 7");
    chk_empty_code: assert property (q_read && !ovf_r && q_cnt_r == '0 |=> tx_r == `KEF_CODE_EMPTY)
        else $error("empty code wrong");
    chk_ovf_code: assert property (q_read && ovf_r |=> tx_r == `KEF_CODE_OVF ##1 !ovf_r || $past(evt_valid))
        else $error("overflow code wrong or flag stuck");
    chk_repeat_code: assert property (q_read && !ovf_r && q_cnt_r != '0 && head[`KEF_ENT_RPT]
        |=> tx_r[7] == 1'b0 && tx_r[5:0] == `KEF_KEY_RPT && tx_r[6] == $past(q_cnt_r > 1))
        else $error("repeat code wrong");
    chk_sleep_write: assert property (wr_cfg && !pwm_cc_en && !wake_evt |=> sleep_r == $past(shift_r[`KEF_CFG_SLEEP]))
        else $error("sleep write not taken");
    chk_pwm_hold: assert property (pwm_cc_en && sleep_r |=> sleep_r && key_active)
        else $error("keys slept under pwm");
    chk_wake_readback: assert property (wake_evt |=> sleep_r ##0 (ptr_r != `KEF_REG_CFG || rd_byte[7]))
        else $error("autowake not seen");
    chk_int_empty: assert property (!cfg_r[`KEF_CFG_INTMODE] && q_cnt_r != '0 |-> !key_int_n)
        else $error("interrupt dropped with queue not empty");
    chk_release_drop: assert property (evt_fire && evt_release && !cfg_r[`KEF_CFG_RELEN] && !b_pop |=> b_cnt_r == $past(b_cnt_r))
        else $error("masked release was queued");

    cov_key_read:  cover property (qnorm ##1 state_r == kef_pkg::ST_RDATA);
    cov_overflow:  cover property (q_read && ovf_r);
    cov_autowake:  cover property (wake_evt);
    cov_cfg_write: cover property (wr_cfg);
endmodule

// *** kef_i2c_host.sv ***
module kef_i2c_host #(
    parameter logic [6:0] ADDR = 7'h38
) (
    input  wire logic core_clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_drv
);
    timeunit 1ns;
    timeprecision 1ns;
    // ********
    // bit level: one bit is 16 clocks, sda changes only while scl is low except for start and stop
    // ********
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic put_bit(input logic b);
        sda_drv = b;
        hold(4);
        scl = 1'b1;
        hold(8);
        scl = 1'b0;
        hold(4);
    endtask
    // sda released, so the pull-up shows unless the device pulls low
    task automatic get_bit(output logic b);
        sda_drv = 1'b1;
        hold(4);
        scl = 1'b1;
        hold(4);
        b = sda_line;
        hold(4);
        scl = 1'b0;
        hold(4);
    endtask
    // start (or repeated start) when a is 1, stop when a is 0
    task automatic cond(input logic a);
        sda_drv = a;
        hold(4);
        scl = 1'b1;
        hold(8);
        sda_drv = ~a;
        hold(8);
        scl = ~a;
        hold(4);
    endtask
    task automatic tx(input logic [7:0] d, inout int nak);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i]);
        end
        get_bit(b);
        nak += int'(b);
    endtask
    // ********
    // pointer write, then one data byte or a repeated start and n reads
    // ********
    task automatic xfer(input logic [7:0] ptr, input logic wr, input logic [7:0] d, input int n,
                        output logic [7:0] q[$], output int nak);
        logic [7:0] r;
        q = {};
        nak = 0;
        cond(1'b1);
        tx({ADDR, 1'b0}, nak);
        tx(ptr, nak);
        if (wr) begin
            tx(d, nak);
        end else begin
            cond(1'b1);
            tx({ADDR, 1'b1}, nak);
            for (int k = 0; k < n; k++) begin
                for (int i = 7; i >= 0; i--) begin
                    get_bit(r[i]);
                end
                q.push_back(r);
                // ack asks for one more byte; nack on the last ends the read
                put_bit(k == n - 1);
            end
        end
        cond(1'b0);
    endtask
endmodule

// *** test_kef_keyscan_fifo.sv ***
module test_kef_keyscan_fifo;
    timeunit 1ns;
    timeprecision 1ns;
    logic       core_clk, srst, scl, sda_drv, sda_o, sda_oe, sda_line, evt_valid, evt_ready;
    logic       evt_release, evt_repeat, pwm_cc_en, autosleep_en, key_active, key_int_n;
    logic [5:0] evt_key;
    logic [7:0] exp_q[$], got_q[$], evq[$];
    int         err_count, samples_checked, nak;

    assign sda_line = sda_drv & ~(sda_oe & ~sda_o);

    kef_keyscan_fifo #(.DEPTH(8), .AUTOSLEEP_CYC(200), .TMO_CYC(500)) i_kef_keyscan_fifo (
        .core_clk(core_clk), .srst(srst), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .evt_valid(evt_valid), .evt_ready(evt_ready), .evt_key(evt_key), .evt_release(evt_release),
        .evt_repeat(evt_repeat), .pwm_cc_en(pwm_cc_en), .autosleep_en(autosleep_en),
        .key_active(key_active), .key_int_n(key_int_n));
    kef_i2c_host i_kef_i2c_host (.core_clk(core_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // ********
    // checks and bus tasks
    // ********
    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        chk8(nm, {7'h00, e}, {7'h00, g});
    endtask
    task automatic give_verdict();
        $display("TB: checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        i_kef_i2c_host.xfer(p, 1'b1, d, 0, got_q, nak);
        chk8("write ack", 8'h00, nak[7:0]);
    endtask
    // reads as many bytes from p as exp_q holds and compares each
    task automatic rd(input logic [7:0] p);
        i_kef_i2c_host.xfer(p, 1'b0, 8'h00, exp_q.size(), got_q, nak);
        chk8("read ack", 8'h00, nak[7:0]);
        foreach (exp_q[i]) chk8("read byte", exp_q[i], got_q[i]);
    endtask
    // entries are {repeat, release, key}; valid is held until taken
    task automatic send_all();
        int w;
        foreach (evq[i]) begin
            @(negedge core_clk);
            evt_valid = 1'b1;
            {evt_repeat, evt_release, evt_key} = evq[i];
            w = 0;
            while (evt_ready !== 1'b1) begin
                w++;
                if (w > 50) begin
                    err_count++;
                    give_verdict();
                end
                @(negedge core_clk);
            end
            @(posedge core_clk);
        end
        @(negedge core_clk);
        evt_valid = 1'b0;
        repeat (4) @(negedge core_clk);
    endtask

    initial begin
        #900000;
        $display("TB: watchdog expired");
        err_count++;
        give_verdict();
    end
    // ********
    // main sequence
    // ********
    initial begin
        {srst, evt_valid, evt_key, evt_release, evt_repeat, pwm_cc_en, autosleep_en} = 12'h800;
        err_count = 0;
        samples_checked = 0;
        repeat (4) @(negedge core_clk);
        srst = 1'b0;
        repeat (4) @(negedge core_clk);
        chk1("key_int_n", 1'b1, key_int_n);
        chk1("key_active", 1'b0, key_active);
        exp_q = '{8'h08};
        rd(8'h01);
        exp_q = '{8'h3F};
        rd(8'h00);
        wr(8'h01, 8'hFF);
        chk1("key_active", 1'b1, key_active);
        exp_q = '{8'hAB};
        rd(8'h01);
        $display("TB: reset and config test done");
        wr(8'h01, 8'h88);
        evq = '{8'h05, 8'h80, 8'h45, 8'h3E, 8'h7F, 8'h00};
        send_all();
        chk1("key_int_n", 1'b0, key_int_n);
        exp_q = '{8'h85, 8'h7E, 8'hC5, 8'hBE, 8'hFF, 8'h00, 8'h3F};
        rd(8'h00);
        chk1("key_int_n", 1'b1, key_int_n);
        wr(8'h01, 8'h80);
        evq = '{8'h43, 8'h03};
        send_all();
        exp_q = '{8'h03, 8'h3F};
        rd(8'h00);
        $display("TB: format test done");
        wr(8'h01, 8'hA8);
        evq = '{8'h01, 8'h02};
        send_all();
        chk1("key_int_n", 1'b0, key_int_n);
        exp_q = '{8'h81};
        rd(8'h00);
        chk1("key_int_n", 1'b1, key_int_n);
        exp_q = '{8'h02, 8'h3F};
        rd(8'h00);
        wr(8'h01, 8'h88);
        $display("TB: interrupt test done");
        evq = {};
        exp_q = '{8'h7F};
        for (int k = 10; k < 20; k++) begin
            evq.push_back(8'(k));
            exp_q.push_back(8'h80 | 8'(k));
        end
        exp_q[10] = 8'h13;
        exp_q.push_back(8'h3F);
        send_all();
        @(negedge core_clk);
        evt_valid = 1'b1;
        repeat (4) @(negedge core_clk);
        chk1("evt_ready", 1'b0, evt_ready);
        evt_valid = 1'b0;
        rd(8'h00);
        $display("TB: overflow test done");
        pwm_cc_en = 1'b1;
        wr(8'h01, 8'h08);
        chk1("key_active", 1'b1, key_active);
        exp_q = '{8'h88};
        rd(8'h01);
        pwm_cc_en = 1'b0;
        @(negedge core_clk);
        chk1("key_active", 1'b1, key_active);
        wr(8'h01, 8'h08);
        chk1("key_active", 1'b0, key_active);
        evq = '{8'h04};
        send_all();
        exp_q = '{8'h3F};
        rd(8'h00);
        $display("TB: sleep test done");
        wr(8'h01, 8'h8A);
        autosleep_en = 1'b1;
        repeat (300) @(negedge core_clk);
        chk1("key_active", 1'b0, key_active);
        exp_q = '{8'h0A};
        rd(8'h01);
        evq = '{8'h07};
        send_all();
        chk1("key_active", 1'b1, key_active);
        autosleep_en = 1'b0;
        exp_q = '{8'h07};
        rd(8'h00);
        $display("TB: autosleep test done");
        give_verdict();
    end
endmodule
